// >>> verilog/hpp_regs.svh
`ifndef HPP_REGS_SVH
`define HPP_REGS_SVH
// ----------------------------------------------------------------
// bus widths and fixed addresses
// ----------------------------------------------------------------
`define HPP_AW          8
`define HPP_DW          32
`define HPP_ADDR_FIFO   8'hff
`define HPP_ADDR_DMA    8'h80
// ----------------------------------------------------------------
// register indices reached by programmed access
// ----------------------------------------------------------------
`define HPP_REG_PATH    8'h00
`define HPP_REG_COUNT   8'h01
`define HPP_REG_DIR     8'h02
`define HPP_REG_STATUS  8'h03
// ----------------------------------------------------------------
// transfer path codes, fifo shape and host step length
// ----------------------------------------------------------------
`define HPP_PATH_NONE   2'h0
`define HPP_PATH_DMA    2'h1
`define HPP_PATH_FIFO   2'h2
`define HPP_FIFO_DEPTH  16
`define HPP_HOST_STEP   8
`endif

// >>> verilog/hpp_pkg.sv
package hpp_pkg;
`include "hpp_regs.svh"
   // ----------------------------------------------------------------
   // pin bundle as the device sees it after synchronising
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                cs_n;
      logic                oe_n;
      logic                we_n;
      logic                grant_n;
      logic                more;
      logic                attn;
      logic [`HPP_AW-1:0]  addr;
      logic [`HPP_DW-1:0]  data;
   } hpp_pins_s;

   typedef enum logic [2:0] {
      D_IDLE = 3'h0, D_SCAN = 3'h1, D_ACC = 3'h3, D_REL = 3'h2,
      D_DREQ = 3'h6, D_DCYC = 3'h7, D_DEND = 3'h5
   } hpp_dev_e;

   typedef enum logic [3:0] {
      H_IDLE = 4'h0, H_ATTN = 4'h1, H_PUL = 4'h3, H_RDY = 4'h2,
      H_CS = 4'h6, H_WLO = 4'h7, H_WHI = 4'h5, H_SOFF = 4'h4,
      H_COFF = 4'hc, H_END = 4'hd, H_DGNT = 4'hf, H_DCS = 4'he,
      H_DSTB = 4'ha, H_DSOF = 4'hb, H_DCOF = 4'h9, H_DGAP = 4'h8
   } hpp_host_e;

   typedef enum logic {OP_RD = 1'b0, OP_WR = 1'b1} hpp_op_e;
endpackage

// >>> verilog/hpp_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// parallel port wires between processor and device
// ----------------------------------------------------------------
interface hpp_if;
   import hpp_pkg::*;
   logic [`HPP_AW-1:0] addr;
   logic [`HPP_DW-1:0] h_data;
   logic               h_doe;
   logic               cs_n;
   logic               oe_n;
   logic               we_n;
   logic               more;
   logic               host_attention_pulse;
   logic               xfer_grant_n;
   logic [`HPP_DW-1:0] d_data;
   logic               d_doe;
   logic               ready;
   logic               wait_drv_n;
   logic               wait_oe;
   logic               xfer_request_n;
   logic [`HPP_DW-1:0] data;
   logic               wait_n;

   // shared data bus; an undriven bus reads as zero
   assign data   = d_doe ? d_data : (h_doe ? h_data : '0);
   // wait line is pulled up whenever the device lets go of it
   assign wait_n = wait_oe ? wait_drv_n : 1'b1;

   modport dev  (input addr, cs_n, oe_n, we_n, more, host_attention_pulse, xfer_grant_n, data,
                 output d_data, d_doe, ready, wait_drv_n, wait_oe, xfer_request_n);
   modport host (input data, ready, wait_n, xfer_request_n,
                 output addr, h_data, h_doe, cs_n, oe_n, we_n, more, host_attention_pulse, xfer_grant_n);
endinterface

// >>> verilog/hpp_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// synchronous word fifo, valid/ready on both sides
// ----------------------------------------------------------------
module hpp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_in_data,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   output logic      [WIDTH-1:0] o_out_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW:0]                 wr;
      logic [PW:0]                 rd;
   } hpp_fifo_s;

   hpp_fifo_s q;
   hpp_fifo_s next_q;
   logic      full;
   logic      empty;

   // extra pointer bit tells full from empty
   assign empty       = (q.wr == q.rd);
   assign full        = (q.wr[PW] != q.rd[PW]) && (q.wr[PW-1:0] == q.rd[PW-1:0]);
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = q.mem[q.rd[PW-1:0]];

   // pointer moves on each accepted handshake
   always_comb begin
      next_q = q;
      if (i_in_valid && !full) begin
         next_q.mem[q.wr[PW-1:0]] = i_in_data;
         next_q.wr = q.wr + 1'b1;
      end
      if (i_out_ready && !empty) begin
         next_q.rd = q.rd + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule

// >>> verilog/hpp_device_end.sv
`timescale 1ns/1ps
module hpp_device_end
   import hpp_pkg::*;
#(
   parameter int DEPTH = `HPP_FIFO_DEPTH
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_n,
   hpp_if.dev                     port,
   output logic [`HPP_DW-1:0]     o_rx_data,
   output logic                   o_rx_valid,
   input  wire logic              i_rx_ready,
   input  wire logic [`HPP_DW-1:0] i_tx_data,
   input  wire logic              i_tx_valid,
   output logic                   o_tx_ready
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      hpp_pins_s          s1;
      hpp_pins_s          s2;
      logic               attn_q;
      hpp_dev_e           st;
      logic               ready;
      logic               pio;
      logic               rd;
      logic               req;
      logic [`HPP_DW-1:0] dout;
      logic [1:0]         path;
      logic [`HPP_DW-1:0] count;
      logic               to_host;
      logic [`HPP_DW-1:0] done;
   } hpp_dev_s;

   hpp_dev_s           q;
   hpp_dev_s           next_q;
   hpp_pins_s          pins;
   hpp_pins_s          s;
   logic               rx_push;
   logic               rx_in_ready;
   logic               tx_pop;
   logic               tx_valid;
   logic [`HPP_DW-1:0] tx_word;
   logic               cs;
   logic               rd_s;
   logic               wr_s;
   logic               gnt;
   logic               fifo_hit;

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   // unmapped indices read as zero
   function automatic logic [`HPP_DW-1:0] reg_read(input hpp_dev_s r, input logic [`HPP_AW-1:0] a);
      logic [`HPP_DW-1:0] v;
      v = '0;
      case (a)
         `HPP_REG_PATH:   v[1:0] = r.path;
         `HPP_REG_COUNT:  v = r.count;
         `HPP_REG_DIR:    v[0] = r.to_host;
         `HPP_REG_STATUS: v = r.done;
         default:         v = '0;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // fifos: rx carries processor writes, tx feeds processor reads
   // ----------------------------------------------------------------
   hpp_fifo #(.WIDTH(`HPP_DW), .DEPTH(DEPTH)) u_rx (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_in_data   (s.data),
      .i_in_valid  (rx_push),
      .o_in_ready  (rx_in_ready),
      .o_out_data  (o_rx_data),
      .o_out_valid (o_rx_valid),
      .i_out_ready (i_rx_ready)
   );

   hpp_fifo #(.WIDTH(`HPP_DW), .DEPTH(DEPTH)) u_tx (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_in_data   (i_tx_data),
      .i_in_valid  (i_tx_valid),
      .o_in_ready  (o_tx_ready),
      .o_out_data  (tx_word),
      .o_out_valid (tx_valid),
      .i_out_ready (tx_pop)
   );

   // ----------------------------------------------------------------
   // port view; only the second sync stage is ever decoded
   // ----------------------------------------------------------------
   assign pins     = '{cs_n: port.cs_n, oe_n: port.oe_n, we_n: port.we_n, grant_n: port.xfer_grant_n,
                       more: port.more, attn: port.host_attention_pulse, addr: port.addr, data: port.data};
   assign s        = q.s2;
   assign cs       = !s.cs_n;
   assign rd_s     = !s.oe_n;
   assign wr_s     = !s.we_n;
   assign gnt      = !s.grant_n;
   assign fifo_hit = (s.addr == `HPP_ADDR_FIFO);

   // outputs; wait is let go entirely outside programmed access
   assign port.ready          = q.ready;
   assign port.xfer_request_n = !q.req;
   assign port.wait_drv_n     = (q.st != D_ACC);
   assign port.wait_oe        = (q.st == D_SCAN) || (q.st == D_ACC) || (q.st == D_REL);
   assign port.d_data         = q.dout;
   assign port.d_doe          = q.rd && cs && rd_s && ((q.st == D_REL) || (q.st == D_DEND));

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_q        = q;
      next_q.s1     = pins;
      next_q.s2     = q.s1;
      next_q.attn_q = s.attn;
      rx_push       = 1'b0;
      tx_pop        = 1'b0;
      unique case (q.st)
         D_IDLE: begin
            if (s.attn && !q.attn_q && s.more) begin
               next_q.ready = 1'b1;
               next_q.pio   = 1'b1;
               next_q.st    = D_SCAN;
            end else if (cs && fifo_hit) begin
               next_q.st = D_ACC;
            end else if (q.path == `HPP_PATH_DMA && q.count != '0) begin
               next_q.req  = 1'b1;
               next_q.done = '0;
               next_q.st   = D_DREQ;
            end
         end
         D_SCAN: begin
            // address and select may settle in either order
            if (!s.more) begin
               next_q.ready = 1'b0;
               next_q.pio   = 1'b0;
               next_q.st    = D_IDLE;
            end else if (cs) begin
               next_q.st = D_ACC;
            end
         end
         D_ACC: begin
            // an empty or full fifo keeps wait low, pacing the processor
            if (rd_s) begin
               if (!fifo_hit) begin
                  next_q.dout = reg_read(q, s.addr);
                  next_q.rd   = 1'b1;
                  next_q.st   = D_REL;
               end else if (tx_valid) begin
                  tx_pop      = 1'b1;
                  next_q.dout = tx_word;
                  next_q.rd   = 1'b1;
                  next_q.st   = D_REL;
               end
            end else if (wr_s) begin
               next_q.rd = 1'b0;
               if (!fifo_hit) begin
                  next_q.st = D_REL;
                  case (s.addr)
                     `HPP_REG_PATH:  next_q.path = s.data[1:0];
                     `HPP_REG_COUNT: next_q.count = s.data;
                     `HPP_REG_DIR:   next_q.to_host = s.data[0];
                     default:        next_q.path = q.path;
                  endcase
               end else if (rx_in_ready) begin
                  rx_push   = 1'b1;
                  next_q.st = D_REL;
               end
            end
         end
         D_REL: begin
            if (!cs) begin
               if (q.pio && s.more) begin
                  next_q.st = D_SCAN;
               end else begin
                  next_q.ready = 1'b0;
                  next_q.pio   = 1'b0;
                  next_q.st    = D_IDLE;
               end
            end
         end
         D_DREQ: begin
            if (gnt) begin
               next_q.req = 1'b0;
               next_q.st  = D_DCYC;
            end
         end
         D_DCYC: begin
            // the address lines are ignored; grant together with select picks the fifo
            if (gnt && cs && q.to_host && rd_s && tx_valid) begin
               tx_pop      = 1'b1;
               next_q.dout = tx_word;
               next_q.rd   = 1'b1;
               next_q.done = q.done + 1'b1;
               next_q.st   = D_DEND;
            end else if (gnt && cs && !q.to_host && wr_s && rx_in_ready) begin
               rx_push     = 1'b1;
               next_q.rd   = 1'b0;
               next_q.done = q.done + 1'b1;
               next_q.st   = D_DEND;
            end
         end
         D_DEND: begin
            // block mode: further cycles come by regrant, not by a new request
            if (!gnt) begin
               if (q.done == q.count) begin
                  next_q.path = `HPP_PATH_NONE;
                  next_q.st   = D_IDLE;
               end else begin
                  next_q.st = D_DCYC;
               end
            end
         end
         default: begin
            next_q.st = D_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
endmodule

// >>> verilog/hpp_host_end.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// processor side: programmed access sequencer and dma controller
// ----------------------------------------------------------------
module hpp_host_end
   import hpp_pkg::*;
#(
   parameter int STEP = `HPP_HOST_STEP
) (
   input  wire logic               i_ref_clk,
   input  wire logic               i_rst_n,
   hpp_if.host                     port,
   input  wire logic               i_cmd_valid,
   input  wire hpp_op_e            i_cmd_op,
   input  wire logic [`HPP_AW-1:0] i_cmd_addr,
   input  wire logic [`HPP_DW-1:0] i_cmd_wdata,
   input  wire logic               i_cmd_keep,
   output logic                    o_cmd_ready,
   output logic                    o_rsp_valid,
   output logic [`HPP_DW-1:0]      o_rsp_data,
   input  wire logic               i_dma_start,
   input  wire logic               i_dma_to_mem,
   input  wire logic [15:0]        i_dma_count,
   input  wire logic [`HPP_DW-1:0] i_dma_wdata,
   output logic                    o_dma_busy,
   output logic                    o_dma_valid,
   output logic [`HPP_DW-1:0]      o_dma_data
);
   typedef struct packed {
      logic [2:0]         s1;
      logic [2:0]         s2;
      logic [`HPP_DW-1:0] d1;
      logic [`HPP_DW-1:0] d2;
      hpp_host_e          st;
      logic [7:0]         t;
      hpp_op_e            op;
      logic               keep;
      logic               sess;
      logic [`HPP_AW-1:0] addr;
      logic [`HPP_DW-1:0] wdata;
      logic               cs_n;
      logic               oe_n;
      logic               we_n;
      logic               doe;
      logic               more;
      logic               attn;
      logic               grant_n;
      logic               to_mem;
      logic [15:0]        left;
      logic               rsp;
      logic [`HPP_DW-1:0] rdata;
      logic               dval;
   } hpp_host_s;

   hpp_host_s q;
   hpp_host_s next_q;
   logic      ready_s;
   logic      wait_s;
   logic      req_s;
   logic      tick;

   assign ready_s = q.s2[2];
   assign wait_s  = !q.s2[1];
   assign req_s   = !q.s2[0];
   assign tick    = (q.t == '0);

   assign port.addr                 = q.addr;
   assign port.h_data               = q.wdata;
   assign port.h_doe                = q.doe;
   assign port.cs_n                 = q.cs_n;
   assign port.oe_n                 = q.oe_n;
   assign port.we_n                 = q.we_n;
   assign port.more                 = q.more;
   assign port.host_attention_pulse = q.attn;
   assign port.xfer_grant_n         = q.grant_n;
   assign o_cmd_ready = (q.st == H_IDLE) && (q.left == '0) && !i_dma_start;
   assign o_rsp_valid = q.rsp;
   assign o_rsp_data  = q.rdata;
   assign o_dma_busy  = (q.left != '0);
   assign o_dma_valid = q.dval;
   assign o_dma_data  = q.rdata;

   // ----------------------------------------------------------------
   // sequencer; each step not paced by ready or wait is held STEP cycles so the device sees it
   // ----------------------------------------------------------------
   always_comb begin
      next_q      = q;
      next_q.s1   = {port.ready, port.wait_n, port.xfer_request_n};
      next_q.s2   = q.s1;
      next_q.d1   = port.data;
      next_q.d2   = q.d1;
      next_q.rsp  = 1'b0;
      next_q.dval = 1'b0;
      if (!tick) begin
         next_q.t = q.t - 1'b1;
      end
      unique case (q.st)
         H_IDLE: begin
            if (i_dma_start && q.left == '0) begin
               next_q.left   = i_dma_count;
               next_q.to_mem = i_dma_to_mem;
            end else if (q.left != '0 && req_s) begin
               next_q.grant_n = 1'b0;
               next_q.t       = 8'(STEP);
               next_q.st      = H_DGNT;
            end else if (i_cmd_valid && o_cmd_ready) begin
               next_q.op    = i_cmd_op;
               next_q.addr  = i_cmd_addr;
               next_q.wdata = i_cmd_wdata;
               next_q.keep  = i_cmd_keep;
               next_q.t     = 8'(STEP);
               if (i_cmd_addr == `HPP_ADDR_FIFO || q.sess) begin
                  next_q.st = H_CS;
               end else begin
                  next_q.more = 1'b1;
                  next_q.st   = H_ATTN;
               end
            end
         end
         H_ATTN: if (tick) begin
            next_q.attn = 1'b1;
            next_q.t    = 8'(STEP);
            next_q.st   = H_PUL;
         end
         H_PUL: if (tick) begin
            next_q.attn = 1'b0;
            next_q.st   = H_RDY;
         end
         H_RDY: if (ready_s) begin
            next_q.sess = 1'b1;
            next_q.cs_n = 1'b0;
            next_q.t    = 8'(STEP);
            next_q.st   = H_CS;
         end
         H_CS: if (tick) begin
            next_q.cs_n = 1'b0;
            next_q.oe_n = (q.op != OP_RD);
            next_q.we_n = (q.op != OP_WR);
            next_q.doe  = (q.op == OP_WR);
            next_q.st   = H_WLO;
         end
         H_WLO: if (wait_s) begin
            next_q.st = H_WHI;
         end
         H_WHI: if (!wait_s) begin
            next_q.rdata = q.d2;
            next_q.rsp   = (q.op == OP_RD);
            next_q.oe_n  = 1'b1;
            next_q.we_n  = 1'b1;
            next_q.doe   = 1'b0;
            // mode-hold drops before select so the device sees it on release
            if (!q.keep && q.sess) begin
               next_q.more = 1'b0;
            end
            next_q.t  = 8'(STEP);
            next_q.st = H_SOFF;
         end
         H_SOFF: if (tick) begin
            next_q.cs_n = 1'b1;
            next_q.st   = (!q.keep && q.sess) ? H_END : H_IDLE;
         end
         H_END: if (!ready_s) begin
            next_q.sess = 1'b0;
            next_q.st   = H_IDLE;
         end
         H_DGNT: if (tick) begin
            next_q.addr = `HPP_ADDR_DMA;
            next_q.cs_n = 1'b0;
            next_q.t    = 8'(STEP);
            next_q.st   = H_DCS;
         end
         H_DCS: if (tick) begin
            next_q.oe_n  = !q.to_mem;
            next_q.we_n  = q.to_mem;
            next_q.doe   = !q.to_mem;
            next_q.wdata = i_dma_wdata;
            next_q.t     = 8'(STEP);
            next_q.st    = H_DSTB;
         end
         H_DSTB: if (tick) begin
            next_q.rdata = q.d2;
            next_q.dval  = q.to_mem;
            next_q.oe_n  = 1'b1;
            next_q.we_n  = 1'b1;
            next_q.doe   = 1'b0;
            next_q.t     = 8'(STEP);
            next_q.st    = H_DSOF;
         end
         H_DSOF: if (tick) begin
            next_q.cs_n = 1'b1;
            next_q.t    = 8'(STEP);
            next_q.st   = H_DCOF;
         end
         H_DCOF: if (tick) begin
            next_q.grant_n = 1'b1;
            next_q.left    = q.left - 1'b1;
            next_q.t       = 8'(STEP);
            next_q.st      = H_DGAP;
         end
         H_DGAP: if (tick) begin
            next_q.grant_n = (q.left == '0);
            next_q.t       = 8'(STEP);
            next_q.st      = (q.left == '0) ? H_IDLE : H_DGNT;
         end
         default: next_q.st = H_IDLE;
      endcase
   end

   // strobes and grant idle high after reset; hold, attention and address reset low
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q         <= '0;
         q.cs_n    <= 1'b1;
         q.oe_n    <= 1'b1;
         q.we_n    <= 1'b1;
         q.grant_n <= 1'b1;
         q.s1      <= 3'h3;
         q.s2      <= 3'h3;
      end else begin
         q <= next_q;
      end
   end
endmodule

// >>> dv/hpp_properties.sv
`timescale 1ns/1ps
// ----
// port protocol checks
// ----
module hpp_properties (
   input wire logic       i_ref_clk,
   input wire logic       i_rst_n,
   input wire logic [7:0] addr,
   input wire logic       cs_n,
   input wire logic       oe_n,
   input wire logic       more,
   input wire logic       xfer_grant_n,
   input wire logic       d_doe,
   input wire logic       ready,
   input wire logic       wait_n,
   input wire logic       xfer_request_n
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   property p_rdy_on; $rose(ready) |-> more; endproperty
   a_rdy_on: assert property (p_rdy_on) else $error("ready without hold");
   property p_rd_data; $rose(wait_n) && !oe_n && xfer_grant_n |-> ##[0:1] d_doe; endproperty
   a_rd_data: assert property (p_rd_data) else $error("read data late");
   // a dropped hold must end the session within the sync lag
   property p_rdy_drop; ready && !more && $rose(cs_n) |-> ##[2:5] !ready; endproperty
   a_rdy_drop: assert property (p_rdy_drop) else $error("ready stuck");
   property p_rdy_keep; (ready && more)[*4] |=> ready; endproperty
   a_rdy_keep: assert property (p_rdy_keep) else $error("ready lost");
   property p_req_hold; xfer_grant_n[*4] ##0 !xfer_request_n |=> !xfer_request_n; endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped early");
   property p_dma_wait; !xfer_grant_n |-> wait_n; endproperty
   a_dma_wait: assert property (p_dma_wait) else $error("wait in dma");
   property p_wait_cs; $fell(wait_n) |-> !cs_n && xfer_grant_n; endproperty
   a_wait_cs: assert property (p_wait_cs) else $error("wait without select");
   property p_doe_off; $rose(oe_n) |-> ##[1:5] !d_doe; endproperty
   a_doe_off: assert property (p_doe_off) else $error("bus held");
   property p_quiet; (!ready && xfer_grant_n && addr != 8'hff)[*4] |-> !d_doe && wait_n; endproperty
   a_quiet: assert property (p_quiet) else $error("answer outside scan");
   c_scan: cover property ($rose(ready));
   c_req: cover property ($fell(xfer_request_n));
   c_dma_rd: cover property (d_doe && !xfer_grant_n);
endmodule

// >>> dv/host_processor_port_pio_fifo_dma_tb.sv
`timescale 1ns/1ps
module host_processor_port_pio_fifo_dma_tb;
   import hpp_pkg::*;
   logic        i_ref_clk = 0, i_rst_n = 0, cv = 0, ck = 0, ds = 0, dm = 0, txv = 0, rxr = 0;
   hpp_op_e     op = OP_RD;
   logic [7:0]  ca = '0;
   logic [15:0] dc = '0;
   logic [31:0] cw = '0, txd = '0, dw = '0, rsp, dd, rxd, r;
   logic        crdy, rv, db, dv, rxv, txr;
   int          errors = 0, compares = 0, cyc = 0;
   hpp_if u_hpp_if ();
   hpp_host_end u_hpp_host_end (.i_ref_clk, .i_rst_n, .port(u_hpp_if), .i_cmd_valid(cv), .i_cmd_op(op),
      .i_cmd_addr(ca), .i_cmd_wdata(cw), .i_cmd_keep(ck), .o_cmd_ready(crdy), .o_rsp_valid(rv),
      .o_rsp_data(rsp), .i_dma_start(ds), .i_dma_to_mem(dm), .i_dma_count(dc), .i_dma_wdata(dw),
      .o_dma_busy(db), .o_dma_valid(dv), .o_dma_data(dd));
   hpp_device_end u_hpp_device_end (.i_ref_clk, .i_rst_n, .port(u_hpp_if), .o_rx_data(rxd),
      .o_rx_valid(rxv), .i_rx_ready(rxr), .i_tx_data(txd), .i_tx_valid(txv), .o_tx_ready(txr));
   hpp_properties u_hpp_properties (.i_ref_clk, .i_rst_n, .addr(u_hpp_if.addr), .cs_n(u_hpp_if.cs_n),
      .oe_n(u_hpp_if.oe_n), .more(u_hpp_if.more), .xfer_grant_n(u_hpp_if.xfer_grant_n),
      .d_doe(u_hpp_if.d_doe), .ready(u_hpp_if.ready), .wait_n(u_hpp_if.wait_n),
      .xfer_request_n(u_hpp_if.xfer_request_n));
   // clock, and a cycle ceiling so a hang still reaches the report
   initial forever #25 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         errors++;
         wrap_up;
      end
   end
   task wrap_up;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(string n, logic [31:0] g, logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   // one programmed access; read data lands in r
   task pio(hpp_op_e o, logic [7:0] a, logic [31:0] d, logic k);
      @(posedge i_ref_clk);
      {cv, ca, cw, ck} <= {1'b1, a, d, k};
      op <= o;
      do @(negedge i_ref_clk); while (crdy !== 1'b1);
      @(posedge i_ref_clk);
      cv <= 0;
      if (o == OP_RD) begin
         do @(negedge i_ref_clk); while (rv !== 1'b1);
         r = rsp;
      end
   endtask
   task push(logic [31:0] d);
      @(posedge i_ref_clk);
      {txv, txd} <= {1'b1, d};
      do @(negedge i_ref_clk); while (txr !== 1'b1);
      @(posedge i_ref_clk);
      txv <= 0;
   endtask
   task pop(logic [31:0] e);
      do @(negedge i_ref_clk); while (rxv !== 1'b1);
      chk("rx word", rxd, e);
      @(posedge i_ref_clk);
      rxr <= 1;
      @(posedge i_ref_clk);
      rxr <= 0;
   endtask
   task t_regs;
      pio(OP_WR, 8'h01, 32'h5, 1);
      pio(OP_RD, 8'h01, 0, 1);
      chk("count", r, 32'h5);
      pio(OP_RD, 8'h05, 0, 0);
      chk("unmapped", r, 0);
      repeat (40) @(posedge i_ref_clk);
      chk("ready", u_hpp_if.ready, 0);
      $display("test regs done");
   endtask
   task t_fifo;
      pio(OP_WR, 8'h00, 32'h2, 1);
      pio(OP_RD, 8'h00, 0, 0);
      chk("path fifo", r, 32'h2);
      push(32'ha1);
      push(32'ha2);
      pio(OP_RD, 8'hff, 0, 0);
      chk("fifo rd", r, 32'ha1);
      pio(OP_RD, 8'hff, 0, 0);
      chk("fifo rd", r, 32'ha2);
      pio(OP_WR, 8'hff, 32'hb1, 0);
      pio(OP_WR, 8'hff, 32'hb2, 0);
      pop(32'hb1);
      pop(32'hb2);
      $display("test fifo done");
   endtask
   // three-word block transfer; the host may read status only after it ends
   task t_dma(logic tm);
      pio(OP_WR, 8'h01, 32'h3, 1);
      pio(OP_WR, 8'h02, {31'h0, tm}, 1);
      pio(OP_WR, 8'h00, 32'h1, 0);
      @(posedge i_ref_clk);
      {ds, dm, dc, dw} <= {1'b1, tm, 16'h3, 32'hc7};
      // start is held: the host end only takes it once the last access has closed
      do @(negedge i_ref_clk); while (db !== 1'b1);
      @(posedge i_ref_clk);
      ds <= 0;
      for (int i = 0; i < 3; i++) begin
         if (tm) begin
            do @(negedge i_ref_clk); while (dv !== 1'b1);
            chk("dma rd", dd, 32'hd0 + 32'(i));
         end else
            pop(32'hc7);
      end
      do @(negedge i_ref_clk); while (db !== 1'b0);
      pio(OP_RD, 8'h03, 0, 1);
      chk("done", r, 3);
      pio(OP_RD, 8'h00, 0, 0);
      chk("path", r, 0);
      $display("test dma done");
   endtask
   initial begin
      repeat (20) @(posedge i_ref_clk);
      i_rst_n <= 1;
      t_regs;
      t_fifo;
      t_dma(0);
      push(32'hd0);
      push(32'hd1);
      push(32'hd2);
      t_dma(1);
      wrap_up;
   end
endmodule
